// *** design/wrap_timer.sv ***
// Eight-bit modulo timer with AXI4-Lite register access
// How it works
// - 8-bit up-counter, free running or limited by a modulo value.
// - Prescaler input picks bus, fixed clock, or external rising/falling edges.
// - Prescaler divides by 1, 2, 4 ... 256.
// - With chaining on and external selected, count partner overflows instead.
// - Wait mode does not stop an enabled timer.
// - Stop mode freezes counting whatever the settings; no wake-up from stop.
// - Reset leaving stop restores reset state; interrupt exit keeps state.
// - Debug mode holds the count; clear or limit write still act.
// - External count input passes a two-flop synchroniser before edge use.
// - Overflow flag bit 7 sets on wrap from limit; software cannot set.
// - Flag clears by writing 0 after reading it set.
// - Flag also clears on counter clear or any limit write.
// - Bit 6 enables interrupt; request while enable and flag both set.
// - Bit 5 writing 1 zeroes the count and flag; reads return 0.
// - Bit 4 halts counting, set by reset; clearing resumes.
// - Status bits 3:0 read as zero.
// - Source field bits 5:4; changing it keeps the count.
// - Prescale field bits 3:0; codes above 8 divide by 256.
// - Limit zero is free running; limit write zeroes count and flag.
// - Count increments to the limit, then wraps to zero and sets flag.
//
// Structure overview
// All state sits in one packed struct, registered by one process.
// The next value is built in one combinational process.
// Bus side: AXI4-Lite slave, one write and one read in flight.
// Address and data halves may arrive in either order.
// A write lands one cycle after both halves are held.
// The write answer rises in the same cycle the write lands.
// A read answers one cycle after its address is taken.
// Unmapped offsets answer with a slave error and read as zero.
// Only byte lane 0 carries register data; other lanes are ignored.
// Writes with lane 0 disabled are ignored but still answered.
//
// Count side: four sources feed an 8-bit free prescaler.
// The prescaler only advances on a selected source edge.
// A tick comes out when the selected low bits are all ones.
// Each tick steps the count by one, or wraps it at the limit.
// A wrap raises the flag and a one-cycle overflow pulse.
// The pulse may feed a partner instance's chained input.
//
// Hazards and limits
// External and fixed clocks are asynchronous levels.
// They pass two flops, so edges are seen two cycles late.
// Pins faster than a quarter of the bus clock lose edges.
// Chaining assumes the partner pulse is on this clock.
// Stop and debug freeze counting but keep every register.
// A software clear beats a same-cycle wrap by choice.
// A hardware wrap beats a same-cycle software flag clear.
module wrap_timer #(
  parameter int ADDR_W = 4
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Count sources and system modes
  input  wire logic              ext_count_input,
  input  wire logic              fixed_freq_clock,
  input  wire logic              partner_overflow,
  input  wire logic              chain_enable,
  input  wire logic              stop_mode,
  input  wire logic              debug_active,
  // Results
  output logic                   overflow_pulse,
  output logic                   irq
);

  // Whole module state
  // Bus part: held halves, answers and their payloads.
  // Sync part: two flops plus a last copy per async input.
  // Count part: prescaler, count, limit and control bits.
  // Flag part: overflow flag and its read-before-clear arm.
  // Keeping it in one struct makes reset and hold uniform.
  typedef struct packed {
    logic                  aw_held;
    logic [ADDR_W-1:0]     aw_addr;
    logic                  w_held;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  ext_meta;
    logic                  ext_sync;
    logic                  ext_last;
    logic                  fix_meta;
    logic                  fix_sync;
    logic                  fix_last;
    logic [7:0]            prescale;
    logic [7:0]            count;
    logic [7:0]            limit;
    logic                  overflow_flag;
    logic                  flag_seen;
    logic                  overflow_irq_enable;
    logic                  counter_halt;
    logic [1:0]            source_select;
    logic [3:0]            prescale_select;
    logic                  ovf_pulse;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // Division mask for a prescale code: pulse when low bits all ones
  function automatic logic [7:0] ps_mask(input logic [3:0] code);
    logic [3:0] c;
    c = (code > wrap_timer_pkg::PS_MAX) ? wrap_timer_pkg::PS_MAX : code;
    ps_mask = 8'((9'h001 << c) - 9'h001);
  endfunction

  // Read data for a register offset
  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a, input state_s s);
    logic [7:0] v;
    v = 8'h00;
    unique case (a[3:0])
      wrap_timer_pkg::OFS_STATUS_CONTROL: v = {s.overflow_flag, s.overflow_irq_enable, 1'b0,
                                               s.counter_halt, 4'h0};
      wrap_timer_pkg::OFS_CLOCK_CONFIG:   v = {2'b00, s.source_select, s.prescale_select};
      wrap_timer_pkg::OFS_LIVE_VALUE:     v = s.count;
      wrap_timer_pkg::OFS_WRAP_LIMIT:     v = s.limit;
      default:                            v = 8'h00;
    endcase
    read_word = {24'h000000, v};
  endfunction

  function automatic logic known_addr(input logic [ADDR_W-1:0] a);
    known_addr = (a[3:0] == wrap_timer_pkg::OFS_STATUS_CONTROL) || (a[3:0] == wrap_timer_pkg::OFS_CLOCK_CONFIG) ||
                 (a[3:0] == wrap_timer_pkg::OFS_LIVE_VALUE) || (a[3:0] == wrap_timer_pkg::OFS_WRAP_LIMIT);
  endfunction

  logic       wr_fire;
  logic       wr_sc;
  logic       wr_ck;
  logic       wr_lim;
  logic       rd_fire;
  logic       src_edge;
  logic       tick;
  logic       do_clear;
  logic       wrap;
  logic       run;

  // Handshake outputs: one write and one read in flight
  // Ready lines are combinational from registered state only.
  // No path runs from a valid input to a ready output,
  // so a master cannot form a loop through this block.
  // Answers and data come straight from flops.
  assign s_axi_awready  = !state_reg.aw_held && !state_reg.bvalid;
  assign s_axi_wready   = !state_reg.w_held && !state_reg.bvalid;
  assign s_axi_arready  = !state_reg.rvalid;
  assign s_axi_bvalid   = state_reg.bvalid;
  assign s_axi_bresp    = state_reg.bresp;
  assign s_axi_rvalid   = state_reg.rvalid;
  assign s_axi_rdata    = state_reg.rdata;
  assign s_axi_rresp    = state_reg.rresp;
  assign overflow_pulse = state_reg.ovf_pulse;
  // interrupt while enable and flag set
  assign irq            = state_reg.overflow_irq_enable && state_reg.overflow_flag;

  // Write happens when both halves are held; byte lane 0 carries the data
  assign wr_fire = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
  assign wr_sc   = wr_fire && state_reg.w_strb[0] && state_reg.aw_addr[3:0] == wrap_timer_pkg::OFS_STATUS_CONTROL;
  assign wr_ck   = wr_fire && state_reg.w_strb[0] && state_reg.aw_addr[3:0] == wrap_timer_pkg::OFS_CLOCK_CONFIG;
  assign wr_lim  = wr_fire && state_reg.w_strb[0] && state_reg.aw_addr[3:0] == wrap_timer_pkg::OFS_WRAP_LIMIT;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // clear bit and limit write both zero the count
  assign do_clear = (wr_sc && state_reg.w_data[wrap_timer_pkg::SC_CLEAR_BIT]) || wr_lim;

  // source edge select; chaining replaces the pin
  always_comb begin
    src_edge = 1'b0;
    unique case (wrap_timer_pkg::source_e'(state_reg.source_select))
      wrap_timer_pkg::SRC_BUS:      src_edge = 1'b1;
      wrap_timer_pkg::SRC_FIXED:    src_edge = state_reg.fix_sync && !state_reg.fix_last;
      wrap_timer_pkg::SRC_EXT_FALL: src_edge = chain_enable ? partner_overflow
                                                            : (!state_reg.ext_sync && state_reg.ext_last);
      wrap_timer_pkg::SRC_EXT_RISE: src_edge = chain_enable ? partner_overflow
                                                            : (state_reg.ext_sync && !state_reg.ext_last);
    endcase
  end

  // wait mode is not an input: the timer just keeps running
  // stop freezes; debug holds; halt bit freezes
  assign run  = !state_reg.counter_halt && !stop_mode && !debug_active;
  // prescaler pulse when low bits are all ones
  // mask from prescale code, saturating at 256
  assign tick = run && src_edge &&
                ((state_reg.prescale & ps_mask(state_reg.prescale_select)) == ps_mask(state_reg.prescale_select));
  // wrap at limit; limit zero wraps at full range
  assign wrap = tick && (state_reg.limit == 8'h00 ? state_reg.count == 8'hff : state_reg.count == state_reg.limit);

  // Next-state logic
  // Order of the steps matters: later steps win.
  // 1. Synchronisers shift every cycle.
  // 2. Bus halves captured, write fired, answers retired.
  // 3. Register writes applied from held data.
  // 4. Prescaler advances on each running source edge; count advances on a tick.
  // 5. Wrap sets the flag over a software clear.
  // 6. Clear bit or limit write override everything.
  // Debug and stop only gate the run term, so a clear
  // or limit write still acts while frozen.
  always_comb begin
    state_next = state_reg;
    state_next.ovf_pulse = 1'b0;

    // two flops before edge detection on the pin
    state_next.ext_meta = ext_count_input;
    state_next.ext_sync = state_reg.ext_meta;
    state_next.ext_last = state_reg.ext_sync;
    // Fixed clock comes from another domain, so it gets the same treatment
    state_next.fix_meta = fixed_freq_clock;
    state_next.fix_sync = state_reg.fix_meta;
    state_next.fix_last = state_reg.fix_sync;

    // Capture address and data independently, either order
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = known_addr(state_reg.aw_addr) ? wrap_timer_pkg::RESP_OKAY : wrap_timer_pkg::RESP_SLVERR;
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken
    if (rd_fire) begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = read_word(s_axi_araddr, state_reg);
      state_next.rresp  = known_addr(s_axi_araddr) ? wrap_timer_pkg::RESP_OKAY : wrap_timer_pkg::RESP_SLVERR;
      // arm the clear once the flag has been seen set
      if (s_axi_araddr[3:0] == wrap_timer_pkg::OFS_STATUS_CONTROL && state_reg.overflow_flag) begin
        state_next.flag_seen = 1'b1;
      end
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end

    // Control writes
    if (wr_sc) begin
      state_next.overflow_irq_enable = state_reg.w_data[wrap_timer_pkg::SC_IRQ_EN_BIT];
      state_next.counter_halt        = state_reg.w_data[wrap_timer_pkg::SC_HALT_BIT];
      // writing 0 clears only after an armed read
      if (!state_reg.w_data[wrap_timer_pkg::SC_OVERFLOW_BIT] && state_reg.flag_seen) begin
        state_next.overflow_flag = 1'b0;
        state_next.flag_seen     = 1'b0;
      end
    end
    // source change leaves the count alone
    if (wr_ck) begin
      state_next.source_select   = state_reg.w_data[wrap_timer_pkg::CK_SRC_LSB +: 2];
      state_next.prescale_select = state_reg.w_data[wrap_timer_pkg::CK_PS_LSB +: 4];
    end
    if (wr_lim) begin
      state_next.limit = state_reg.w_data[7:0];
    end

    // Prescaler runs on every selected edge while active
    if (run && src_edge) begin
      state_next.prescale = state_reg.prescale + 8'h01;
    end

    if (tick) begin
      state_next.count = wrap ? 8'h00 : state_reg.count + 8'h01;
    end
    // hardware alone sets the flag; set wins over software clear
    if (wrap) begin
      state_next.overflow_flag = 1'b1;
      state_next.flag_seen     = 1'b0;
      state_next.ovf_pulse     = 1'b1;
    end
    // clear bit or limit write wins over everything, also in debug
    if (do_clear) begin
      state_next.count         = wrap_timer_pkg::COUNT_RESET;
      state_next.prescale      = 8'h00;
      state_next.overflow_flag = 1'b0;
      state_next.flag_seen     = 1'b0;
      state_next.ovf_pulse     = 1'b0;
    end
  end

  // reset restores everything; stop alone keeps state
  // Reset loads constants only; the struct default is zero
  // and the documented non-zero values are laid over it.
  // Halt starts set, so the count stays at zero until
  // software clears the halt bit.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg                 <= '0;
      state_reg.counter_halt    <= wrap_timer_pkg::HALT_RESET;
      state_reg.source_select   <= wrap_timer_pkg::SRC_RESET;
      state_reg.prescale_select <= wrap_timer_pkg::PS_RESET;
      state_reg.limit           <= wrap_timer_pkg::LIMIT_RESET;
      state_reg.count           <= wrap_timer_pkg::COUNT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule // wrap_timer

// *** design/wrap_timer_pkg.sv ***
// Constants shared by the modulo timer design
package wrap_timer_pkg;

  // Register byte offsets (one aligned word each)
  localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_CLOCK_CONFIG   = 4'h4;
  localparam logic [3:0] OFS_LIVE_VALUE     = 4'h8;
  localparam logic [3:0] OFS_WRAP_LIMIT     = 4'hc;

  // Status/control field positions
  localparam int SC_OVERFLOW_BIT = 7;
  localparam int SC_IRQ_EN_BIT   = 6;
  localparam int SC_CLEAR_BIT    = 5;
  localparam int SC_HALT_BIT     = 4;

  // Clock config field positions
  localparam int CK_SRC_LSB = 4;
  localparam int CK_PS_LSB  = 0;

  // Reset values
  localparam logic       HALT_RESET      = 1'b1;
  localparam logic [1:0] SRC_RESET       = 2'h0;
  localparam logic [3:0] PS_RESET        = 4'h0;
  localparam logic [7:0] LIMIT_RESET     = 8'h00;
  localparam logic [7:0] COUNT_RESET     = 8'h00;

  // Largest prescale code; codes above it divide by 256
  localparam logic [3:0] PS_MAX = 4'h8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Clock source codes
  typedef enum logic [1:0] {
    SRC_BUS       = 2'h0,
    SRC_FIXED     = 2'h1,
    SRC_EXT_FALL  = 2'h2,
    SRC_EXT_RISE  = 2'h3
  } source_e;

endpackage

// *** tb/ext_clock_source.sv ***
// External count source model
module ext_clock_source #(
  parameter int HALF = 4
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      level
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // quarter rate limit: toggles only every HALF cycles, still between runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt   <= 0;
      level <= 1'b0;
    end else if (run) begin
      cnt   <= (cnt == HALF - 1) ? 0 : cnt + 1;
      level <= (cnt == HALF - 1) ? ~level : level;
    end
  end
endmodule // ext_clock_source

// *** tb/wrap_timer_checker.sv ***
// Port-level assertions for the modulo timer
module wrap_timer_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        stop_mode,
  input wire logic        debug_active,
  input wire logic        overflow_pulse,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Bus answers and their holding
  // Both halves taken together: held one cycle, answer on the next
  property p_b_next; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid; endproperty
  a_b_next: assert property (p_b_next) else $error("write answer late");
  property p_r_next; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_next: assert property (p_r_next) else $error("read answer late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  // Wrap pulse shape and its effects
  property p_single; overflow_pulse |=> !overflow_pulse; endproperty
  a_single: assert property (p_single) else $error("wrap pulse too long");
  property p_stop; stop_mode && $past(stop_mode) |-> !overflow_pulse; endproperty
  a_stop: assert property (p_stop) else $error("wrap during stop");
  property p_dbg; debug_active && $past(debug_active) |-> !overflow_pulse; endproperty
  a_dbg: assert property (p_dbg) else $error("wrap during debug");
  property p_irq; $rose(irq) |-> overflow_pulse || $past(overflow_pulse); endproperty
  a_irq: assert property (p_irq) else $error("request without wrap");
  cover property (overflow_pulse);
  cover property (irq);
  cover property (stop_mode && s_axi_rvalid);
endmodule // wrap_timer_checker

// *** tb/wrap_timer_tb_top.sv ***
// Self-checking bench for the modulo timer
module wrap_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] SC = wrap_timer_pkg::OFS_STATUS_CONTROL;
  localparam logic [3:0] CK = wrap_timer_pkg::OFS_CLOCK_CONFIG;
  localparam logic [3:0] CN = wrap_timer_pkg::OFS_LIVE_VALUE;
  localparam logic [3:0] MD = wrap_timer_pkg::OFS_WRAP_LIMIT;
  logic        clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        ext_count_input, fixed_freq_clock, partner_overflow, chain_enable, stop_mode, debug_active;
  logic        overflow_pulse, irq, ext_run;
  int          bad_count, total_checks;
  int          cyc = 0;
  wrap_timer dut_u (.*);
  ext_clock_source #(.HALF(4)) src_u (.clk(clk), .rst_n(rst_n), .run(ext_run), .level(ext_count_input));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Fixed clock of 6 cycles, chain pulses every 5, hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    fixed_freq_clock <= (cyc % 6) < 3;
    partner_overflow <= (cyc % 5) == 0;
    if (cyc == 40000) begin
      bad_count++;
      results();
    end
  end
  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Write; each half released when taken, sampled settled at negedge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = ta || (s_axi_awvalid && s_axi_awready);
      tw = tw || (s_axi_wvalid && s_axi_wready);
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!(ta && tw));
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, 32'h0);
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata[7:0];
    chk(s_axi_rresp, 32'h0);
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  // Cycles between two consecutive wrap pulses
  task automatic gap(output int n);
    n = 0;
    do @(negedge clk); while (overflow_pulse !== 1'b1);
    do begin
      @(negedge clk);
      n++;
    end while (overflow_pulse !== 1'b1);
  endtask
  task automatic rate(input logic [1:0] s, input logic [3:0] p, input logic [7:0] m, input logic c, input int e);
    int n;
    chain_enable <= c;
    wr(CK, {2'h0, s, p});
    wr(MD, m);
    gap(n);
    chk(n, e);
  endtask
  task automatic t_reset();
    rc(SC, 8'h10);
    rc(CK, 8'h00);
    rc(MD, 8'h00);
    wr(CN, 8'h55);
    rc(CN, 8'h00);
  endtask
  task automatic t_flag();
    int n;
    logic [7:0] a, b;
    wr(MD, 8'h03);
    wr(SC, 8'h00);
    gap(n);
    chk(n, 4);
    wr(SC, 8'h10);
    rc(SC, 8'h90);
    wr(SC, 8'h10);
    rc(SC, 8'h10);
    rd(CN, a);
    repeat (20) @(posedge clk);
    rd(CN, b);
    chk(b, a);
  endtask
  task automatic t_irq();
    // flag is clear before the enable goes on
    wr(SC, 8'h40);
    do @(negedge clk); while (overflow_pulse !== 1'b1);
    @(negedge clk);
    chk(irq, 1'b1);
    wr(SC, 8'h70);
    rc(SC, 8'h50);
    rc(CN, 8'h00);
    chk(irq, 1'b0);
    wr(SC, 8'h40);
    do @(negedge clk); while (overflow_pulse !== 1'b1);
    wr(SC, 8'h50);
    wr(MD, 8'h03);
    rc(SC, 8'h50);
  endtask
  task automatic t_rates();
    wr(SC, 8'h00);
    for (int p = 0; p < 10; p++) rate(2'h0, 4'(p), 8'h01, 1'b0, 2 << (p > 8 ? 8 : p));
    rate(2'h0, 4'h0, 8'h00, 1'b0, 256);
    rate(2'h1, 4'h0, 8'h01, 1'b0, 12);
    ext_run <= 1'b1;
    rate(2'h3, 4'h0, 8'h01, 1'b0, 16);
    rate(2'h2, 4'h1, 8'h01, 1'b0, 32);
    rate(2'h3, 4'h0, 8'h01, 1'b1, 10);
    ext_run <= 1'b0;
  endtask
  task automatic t_freeze(input logic dbg);
    logic [7:0] a, b;
    wr(CK, 8'h00);
    wr(MD, 8'h00);
    if (dbg) debug_active <= 1'b1;
    else stop_mode <= 1'b1;
    repeat (3) @(posedge clk);
    rd(CN, a);
    repeat (30) @(posedge clk);
    rd(CN, b);
    chk(b, a);
    stop_mode <= 1'b0;
    debug_active <= 1'b0;
    repeat (10) @(posedge clk);
    rd(CN, b);
    chk(b !== a, 1'b1);
  endtask
  initial begin
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {chain_enable, stop_mode, debug_active, ext_run} = '0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wdata = 32'h00000000;
    {bad_count, total_checks} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_flag();
    t_irq();
    t_rates();
    t_freeze(1'b0);
    t_freeze(1'b1);
    results();
  end
endmodule // wrap_timer_tb_top
bind wrap_timer wrap_timer_checker chk_u (.*);
